// [src/exec_pkg.sv]
package exec_pkg;

  localparam int WORD_W = 16;
  localparam int PC_W   = 20;
  localparam int OFS_W  = 10;

  // Status register bit positions.
  localparam int FLAG_C   = 0;
  localparam int FLAG_Z   = 1;
  localparam int FLAG_N   = 2;
  localparam int FLAG_GIE = 3;
  localparam int FLAG_CPU = 4;
  localparam int FLAG_OSC = 5;
  localparam int FLAG_V   = 8;

  localparam logic [15:0] GIE_MASK    = 16'h0008;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [19:0] PC_RESET    = 20'h00000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Register offsets of the Avalon slave, word addressed.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_OPND   = 4'h1;
  localparam logic [3:0] REG_RESULT = 4'h2;
  localparam logic [3:0] REG_FLAGS  = 4'h3;
  localparam logic [3:0] REG_PC     = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;

  // Control word fields.
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_BYTE    = 4;
  localparam int CTRL_OFS_LSB = 8;

  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_SUBTRACT_TWO,
    OP_ADD_ONE,
    OP_ADD_TWO,
    OP_COMPLEMENT,
    OP_IRQ_MASK,
    OP_IRQ_UNMASK,
    OP_BRANCH_ON_CARRY,
    OP_BRANCH_UNSIGNED_GE,
    OP_BRANCH_ON_ZERO_FLAG,
    OP_BRANCH_ON_EQUAL,
    OP_BRANCH_SIGNED_GE
  } op_t;

  typedef struct packed {
    logic [15:0] result;
    logic        n;
    logic        z;
    logic        c;
    logic        v;
  } alu_out_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avl_req_t;

endpackage

// [src/emu_alu.sv]
`timescale 1ns/1ps
module emu_alu (
  input  wire exec_pkg::op_t      op,
  input  wire logic               byte_mode,
  input  wire logic [15:0]        dst,
  output exec_pkg::alu_out_t      res
);
  import exec_pkg::*;

  logic [15:0] sum;
  logic [7:0]  lo;
  logic        msb_in;

  always_comb begin
    lo     = dst[7:0];
    msb_in = byte_mode ? dst[7] : dst[15];
    sum    = dst;
    res    = '0;
    unique case (op)
      OP_SUBTRACT_TWO: begin
        sum   = dst - 16'h0002;
        res.z = byte_mode ? (lo == 8'h02) : (dst == 16'h0002);
        res.c = byte_mode ? (lo > 8'h01) : (dst > 16'h0001);
        res.v = byte_mode ? (lo == 8'h81 || lo == 8'h80)
                          : (dst == 16'h8001 || dst == 16'h8000);
      end
      OP_ADD_ONE: begin
        sum   = dst + 16'h0001;
        res.z = byte_mode ? (lo == 8'hFF) : (dst == 16'hFFFF);
        res.c = res.z;
        res.v = byte_mode ? (lo == 8'h7F) : (dst == 16'h7FFF);
      end
      OP_ADD_TWO: begin
        sum   = dst + 16'h0002;
        res.z = byte_mode ? (lo == 8'hFE) : (dst == 16'hFFFE);
        res.c = byte_mode ? (lo >= 8'hFE) : (dst >= 16'hFFFE);
        res.v = byte_mode ? (lo == 8'h7E || lo == 8'h7F)
                          : (dst == 16'h7FFE || dst == 16'h7FFF);
      end
      OP_COMPLEMENT: begin
        sum   = dst ^ 16'hFFFF;
        res.v = msb_in;
      end
      default: begin
        sum = dst;
      end
    endcase
    // Byte operations clear the upper byte of the destination.
    res.result = byte_mode ? {8'h00, sum[7:0]} : sum;
    if (op == OP_COMPLEMENT) begin
      res.z = (res.result == 16'h0000);
      res.c = !res.z;
    end
    res.n = byte_mode ? sum[7] : sum[15];
  end

endmodule // emu_alu

// [src/emu_exec.sv]
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module emu_exec (
  input  wire  logic        clk,
  input  wire  logic        rst_n,
  input  wire  logic        clk_en,
  input  wire  logic [3:0]  avs_address,
  input  wire  logic        avs_read,
  input  wire  logic        avs_write,
  input  wire  logic [31:0] avs_writedata,
  output logic       [31:0] avs_readdata,
  output logic              avs_waitrequest,
  input  wire  logic        irq_request,
  output logic              irq_accept,
  output logic              global_irq_enable,
  output logic              oscillator_disable,
  output logic              core_halt
);
  import exec_pkg::*;

  avl_req_t    req;
  alu_out_t    alu_res;
  op_t         op;
  logic        byte_mode;
  logic [9:0]  offset;
  logic [15:0] opnd_r;
  logic [15:0] result_r;
  logic [15:0] flags_r;
  logic [19:0] pc_r;
  logic        ack_r;
  logic        hold_irq_r;
  logic        irq_sync1_r;
  logic        irq_sync2_r;
  logic        exec_go;
  logic        taken;
  logic [19:0] pc_nxt;
  logic [15:0] flags_nxt;
  logic [31:0] rdata_nxt;
  logic [19:0] step;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata};

  // A write to the control register executes one instruction.
  assign exec_go   = req.write && !ack_r && req.address == REG_CTRL;
  assign op        = op_t'(req.writedata[CTRL_OP_LSB +: 4]);
  assign byte_mode = req.writedata[CTRL_BYTE];
  assign offset    = req.writedata[CTRL_OFS_LSB +: OFS_W];

  emu_alu u_alu (
    .op        (op),
    .byte_mode (byte_mode),
    .dst       (opnd_r),
    .res       (alu_res)
  );

  function automatic logic branch_taken(input op_t o, input logic [15:0] f);
    unique case (o)
      OP_BRANCH_ON_CARRY, OP_BRANCH_UNSIGNED_GE:      return f[FLAG_C];
      OP_BRANCH_ON_ZERO_FLAG, OP_BRANCH_ON_EQUAL:     return f[FLAG_Z];
      OP_BRANCH_SIGNED_GE: return !(f[FLAG_N] ^ f[FLAG_V]);
      default:             return 1'b0;
    endcase
  endfunction

  assign taken = branch_taken(op, flags_r);
  // Offset doubled then sign extended; the counter wraps in 20 bits.
  assign step  = {{(PC_W-OFS_W-1){offset[9]}}, offset, 1'b0};

  always_comb begin
    pc_nxt = pc_r + 20'h00002;
    if (taken) begin
      pc_nxt = pc_r + step;
    end
  end

  always_comb begin
    flags_nxt = flags_r;
    unique case (op)
      OP_SUBTRACT_TWO, OP_ADD_ONE, OP_ADD_TWO, OP_COMPLEMENT: begin
        // Mode bits are never written here.
        flags_nxt[FLAG_N] = alu_res.n;
        flags_nxt[FLAG_Z] = alu_res.z;
        flags_nxt[FLAG_C] = alu_res.c;
        flags_nxt[FLAG_V] = alu_res.v;
      end
      OP_IRQ_MASK:   flags_nxt = flags_r & ~GIE_MASK;
      OP_IRQ_UNMASK: flags_nxt = flags_r | GIE_MASK;
      default:       flags_nxt = flags_r;
    endcase
  end

  // One wait state: every request is answered at the second edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else if (clk_en) begin
      ack_r <= (req.read || req.write) && !ack_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= !((req.read || req.write) && !ack_r);
    end
  end

  always_comb begin
    unique case (req.address)
      REG_CTRL:   rdata_nxt = {28'h0000000, 4'(op_t'(OP_NONE))};
      REG_OPND:   rdata_nxt = {16'h0000, opnd_r};
      REG_RESULT: rdata_nxt = {16'h0000, result_r};
      REG_FLAGS:  rdata_nxt = {16'h0000, flags_r};
      REG_PC:     rdata_nxt = {12'h000, pc_r};
      REG_STATUS: rdata_nxt = {30'h0, hold_irq_r, irq_accept};
      default:    rdata_nxt = UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en && req.read && !ack_r) begin
      avs_readdata <= rdata_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opnd_r <= RESULT_RESET;
    end else if (clk_en && req.write && !ack_r && req.address == REG_OPND) begin
      opnd_r <= req.writedata[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= RESULT_RESET;
      pc_r     <= PC_RESET;
    end else if (clk_en) begin
      if (exec_go) begin
        result_r <= alu_res.result;
        pc_r     <= pc_nxt;
      end else if (req.write && !ack_r && req.address == REG_PC) begin
        pc_r <= req.writedata[19:0];
      end
    end
  end

  // Software may load the whole flags register; execution updates it otherwise.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= FLAGS_RESET;
    end else if (clk_en) begin
      if (exec_go) begin
        flags_r <= flags_nxt;
      end else if (req.write && !ack_r && req.address == REG_FLAGS) begin
        flags_r <= req.writedata[15:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sync1_r <= 1'b0;
      irq_sync2_r <= 1'b0;
    end else if (clk_en) begin
      irq_sync1_r <= irq_request;
      irq_sync2_r <= irq_sync1_r;
    end
  end

  // After an unmask that sets GIE from clear the following instruction is shielded, so a pending
  // request cannot slip in between; the shield drops once it has run.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_irq_r <= 1'b0;
    end else if (clk_en && exec_go) begin
      hold_irq_r <= (op == OP_IRQ_UNMASK) && !flags_r[FLAG_GIE];
    end
  end

  // Acceptance is sampled at instruction boundaries only. An interrupt may
  // still be taken right after a mask op, which software must allow for.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_accept <= 1'b0;
    end else if (clk_en) begin
      irq_accept <= exec_go && irq_sync2_r && flags_r[FLAG_GIE] && !hold_irq_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable  <= 1'b0;
      oscillator_disable <= 1'b0;
      core_halt          <= 1'b0;
    end else if (clk_en) begin
      global_irq_enable  <= flags_nxt[FLAG_GIE] & exec_go | flags_r[FLAG_GIE] & !exec_go;
      oscillator_disable <= flags_r[FLAG_OSC];
      core_halt          <= flags_r[FLAG_CPU];
    end
  end

endmodule // emu_exec

// [tb/emu_exec_assertions.sv]
`timescale 1ns/1ps
module emu_exec_assertions (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq_request,
  input wire logic        irq_accept,
  input wire logic        global_irq_enable,
  input wire logic        oscillator_disable,
  input wire logic        core_halt
);
  import exec_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Four edges cover the write edge plus the two-stage lag of the copied mode bits.
  logic [3:0] fw_r;
  logic [3:0] aw_r;
  logic [3:0] ir_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fw_r <= 4'h0;
      aw_r <= 4'h0;
      ir_r <= 4'h0;
    end else begin
      fw_r <= {fw_r[2:0], avs_write && avs_address == REG_FLAGS};
      aw_r <= {aw_r[2:0], avs_write || irq_accept};
      ir_r <= {ir_r[2:0], irq_request};
    end
  end
  sequence req_rise;
    $rose(avs_read || avs_write);
  endsequence
  sequence acked;
    ##[1:4] !avs_waitrequest;
  endsequence
  AST_ACK_BOUND: assert property (req_rise |-> acked) else $error("request not answered");
  AST_ACK_ONE: assert property ((avs_read || avs_write) && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_RD_STANDS: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("readdata moved without a read");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > REG_STATUS
    |-> avs_readdata == UNMAPPED_DATA) else $error("unmapped read not zero");
  AST_OSC_SRC: assert property ($changed(oscillator_disable) |-> |fw_r)
    else $error("oscillator bit moved without flags write");
  AST_HALT_SRC: assert property ($changed(core_halt) |-> |fw_r)
    else $error("halt bit moved without flags write");
  AST_GIE_SRC: assert property ($changed(global_irq_enable) |-> |aw_r)
    else $error("interrupt enable moved without cause");
  AST_ACC_PULSE: assert property (irq_accept |=> !irq_accept) else $error("accept not a pulse");
  AST_ACC_CAUSE: assert property (irq_accept |-> |ir_r)
    else $error("accept without pending request");
endmodule // emu_exec_assertions

bind emu_exec emu_exec_assertions chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq_request(irq_request), .irq_accept(irq_accept),
  .global_irq_enable(global_irq_enable), .oscillator_disable(oscillator_disable),
  .core_halt(core_halt));

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import exec_pkg::*;
  typedef struct packed {
    logic [3:0]  op;
    logic        byt;
    logic [9:0]  ofs;
    logic [15:0] fl;
    logic [15:0] dst;
    logic [15:0] res;
    logic [15:0] efl;
    logic [19:0] pc;
  } row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq_request = 1'b0;
  logic        irq_accept;
  logic        global_irq_enable;
  logic        oscillator_disable;
  logic        core_halt;
  logic [31:0] q;
  int          errors = 0;
  int          checks = 0;
  int          accepts = 0;
  int          snap;
  // The GIE and OSC mode bits ride along in the ALU rows so that their survival is checked too.
  row_t        rows [26] = '{
    '{4'h1,1'b0,10'h000,16'h0028,16'h0002,16'h0000,16'h002B,20'h01002},
    '{4'h1,1'b0,10'h000,16'h0028,16'h0001,16'hFFFF,16'h002C,20'h01002},
    '{4'h1,1'b0,10'h000,16'h0028,16'h8001,16'h7FFF,16'h0129,20'h01002},
    '{4'h1,1'b1,10'h000,16'h0028,16'h0080,16'h007E,16'h0129,20'h01002},
    '{4'h2,1'b0,10'h000,16'h0028,16'hFFFF,16'h0000,16'h002B,20'h01002},
    '{4'h2,1'b0,10'h000,16'h0028,16'h7FFF,16'h8000,16'h012C,20'h01002},
    '{4'h2,1'b1,10'h000,16'h0028,16'h00FF,16'h0000,16'h002B,20'h01002},
    '{4'h3,1'b0,10'h000,16'h0028,16'hFFFE,16'h0000,16'h002B,20'h01002},
    '{4'h3,1'b1,10'h000,16'h0028,16'h007F,16'h0081,16'h012C,20'h01002},
    '{4'h4,1'b0,10'h000,16'h0028,16'h8000,16'h7FFF,16'h0129,20'h01002},
    '{4'h4,1'b1,10'h000,16'h0028,16'h0000,16'h00FF,16'h002D,20'h01002},
    '{4'h4,1'b0,10'h000,16'h0028,16'hFFFF,16'h0000,16'h012A,20'h01002},
    '{4'h5,1'b0,10'h000,16'h012F,16'h0000,16'h0000,16'h0127,20'h01002},
    '{4'h6,1'b0,10'h000,16'h0127,16'h0000,16'h0000,16'h012F,20'h01002},
    '{4'h7,1'b0,10'h005,16'h0001,16'h0000,16'h0000,16'h0001,20'h0100A},
    '{4'h7,1'b0,10'h005,16'h0106,16'h0000,16'h0000,16'h0106,20'h01002},
    '{4'h8,1'b0,10'h3FF,16'h0029,16'h0000,16'h0000,16'h0029,20'h00FFE},
    '{4'h9,1'b0,10'h200,16'h0002,16'h0000,16'h0000,16'h0002,20'h00C00},
    '{4'hA,1'b0,10'h1FF,16'h0105,16'h0000,16'h0000,16'h0105,20'h01002},
    '{4'hA,1'b0,10'h1FF,16'h0002,16'h0000,16'h0000,16'h0002,20'h013FE},
    '{4'hB,1'b0,10'h004,16'h0104,16'h0000,16'h0000,16'h0104,20'h01008},
    '{4'hB,1'b0,10'h004,16'h0004,16'h0000,16'h0000,16'h0004,20'h01002},
    '{4'hB,1'b0,10'h004,16'h0100,16'h0000,16'h0000,16'h0100,20'h01002},
    '{4'hB,1'b0,10'h004,16'h0001,16'h0000,16'h0000,16'h0001,20'h01008},
    '{4'h1,1'b1,10'h000,16'h0028,16'h1281,16'h007F,16'h0129,20'h01002},
    '{4'hC,1'b0,10'h005,16'h0107,16'h1234,16'h0000,16'h0107,20'h01002}};

  emu_exec dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_request(irq_request), .irq_accept(irq_accept), .global_irq_enable(global_irq_enable),
    .oscillator_disable(oscillator_disable), .core_halt(core_halt));

  always #2.5 clk = ~clk;
  always @(posedge clk) if (irq_accept === 1'b1) accepts++;

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Only the watchdog ends a wait that never sees waitrequest low.
  task automatic avl(input logic wr_en, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr_en;
    avs_read <= !wr_en;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    avl(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a);
    avl(1'b0, a, 32'h0);
  endtask

  // No completion flag exists for an interrupt boundary, so each step gets settling time.
  task automatic step(input logic [31:0] c);
    wr(REG_CTRL, c);
    repeat (4) @(posedge clk);
  endtask

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_FLAGS);
    check(q, {16'h0, FLAGS_RESET});
    rd(REG_PC);
    check(q, {12'h0, PC_RESET});
    check({29'h0, global_irq_enable, oscillator_disable, core_halt}, 32'h0);
    wr(4'hF, 32'h0000_A5A5);
    rd(4'hF);
    check(q, UNMAPPED_DATA);
    foreach (rows[i]) begin
      wr(REG_FLAGS, {16'h0, rows[i].fl});
      wr(REG_PC, 32'h0000_1000);
      wr(REG_OPND, {16'h0, rows[i].dst});
      wr(REG_CTRL, {14'h0, rows[i].ofs, 3'h0, rows[i].byt, rows[i].op});
      rd(REG_FLAGS);
      check(q, {16'h0, rows[i].efl});
      rd(REG_PC);
      check(q, {12'h0, rows[i].pc});
      rd(REG_RESULT);
      if (rows[i].op < 4'h5) check(q, {16'h0, rows[i].res});
      check({31'h0, global_irq_enable}, {31'h0, rows[i].efl[3]});
    end
    wr(REG_FLAGS, 32'h0000_0030);
    rd(REG_FLAGS);
    check({30'h0, oscillator_disable, core_halt}, 32'h3);
    irq_request <= 1'b1;
    wr(REG_FLAGS, 32'h0);
    snap = accepts;
    step(32'h6);
    rd(REG_STATUS);
    check(q, 32'h0000_0002);
    step(32'h0);
    check(32'(accepts - snap), 32'h0);
    step(32'h0);
    check(32'(accepts > snap), 32'h1);
    // The mask op is followed by a no-op before the protected step.
    step(32'h5);
    step(32'h0);
    snap = accepts;
    step(32'h0);
    check(32'(accepts - snap), 32'h0);
    irq_request <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_FLAGS);
    check(q, {16'h0, FLAGS_RESET});
    print_verdict;
  end
endmodule // testbench
